//--- verilog/bocr_regs.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the boost output control block.
// Assumes: Included by its bare name from the design files of the block.
// Notes: Addresses are seven bits wide, data is eight bits wide.
`ifndef BOCR_REGS_VH
`define BOCR_REGS_VH

// Register offsets.
`define BOCR_ADDR_FUNC_CTRL 7'h00
`define BOCR_ADDR_OUT1_TARGET 7'h03
`define BOCR_ADDR_OUT2_TARGET 7'h04
`define BOCR_ADDR_OUT1_OV_LIMIT 7'h05
`define BOCR_ADDR_OUT2_OV_LIMIT 7'h06
`define BOCR_ADDR_OUT1_PEAK_LIMIT 7'h07
`define BOCR_ADDR_OUT2_PEAK_LIMIT 7'h08
`define BOCR_ADDR_CS_COUNT_LO 7'h41
`define BOCR_ADDR_CS_COUNT_HI 7'h42

// Function control field positions.
`define BOCR_FC_CONFIGURATION_DONE 0
`define BOCR_FC_OUTPUT1_ENABLE 1
`define BOCR_FC_OUTPUT2_ENABLE 2
`define BOCR_FC_CS_LOW_COUNT_ENABLE 3
`define BOCR_FC_IMPL_MASK 8'h0F

// Reset values and code limits.
`define BOCR_RST_FUNC_CTRL 8'h00
`define BOCR_RST_CODE 8'h00
`define BOCR_CODE_OFF 8'h00
`define BOCR_PEAK_CODE_MAX 8'h80

// Serial frame layout: one direction bit, seven address bits, eight data bits.
`define BOCR_FRAME_BITS 5'h10
`define BOCR_CMD_BITS 5'h08
`define BOCR_FRAME_READ_BIT 15

// Gate supply start-up time in microseconds and clock rate in MHz.
`define BOCR_GS_STARTUP_US 100
`define BOCR_CLK_MHZ 125

`endif

//--- verilog/bocr_sync.v
// Purpose: Two flip-flop synchroniser for a group of asynchronous comparator levels.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none

module bocr_sync #(
    parameter WIDTH = 2
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    // First and second stages of the synchroniser.
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // Each bit passes two flops before anyone looks at it.
            always @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= i_async[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_reg;

endmodule

`default_nettype wire

//--- verilog/bocr_top.v
// Purpose: Control registers of a two-output boost converter and the gate drive gating that depends on them.
// Assumes: Serial port pins and drive inputs are synchronous to I_REF_CLK; comparators are asynchronous.
// Notes: Serial port is mode 0, most significant bit first, sixteen bits per frame.
`timescale 1ns/1ns
`default_nettype none
`include "bocr_regs.vh"

// What this block does
// - Output 1 target code zero turns output off.
// - Output 2 target code zero turns output off.
// - Hold gate still while output above limit.
// - Resume gate toggling once output drops below limit.
// - Output 1 limit code zero turns output off.
// - Output 2 limit code zero turns output off.
// - Peak current ends gate pulse until next cycle.
// - Slope compensation stays active during current limit.
// - Function bit 1 enables output 1 in operation.
// - Function bit 2 enables output 2 in operation.
// - Gate supply regulator on when any output on.
// - Gates switch after start-up time and supply good.
// - Function bit 0 selects configuration or operation mode.
// - Function bit 3 enables chip select low counting.
// - Count chip select low time; clear freezes count.
module bocr_top #(
    parameter STARTUP_CYCLES = `BOCR_GS_STARTUP_US * `BOCR_CLK_MHZ,
    parameter STARTUP_WIDTH = 16,
    parameter COUNT_WIDTH = 16
) (
    input wire I_REF_CLK,
    input wire I_RST_B,
    input wire I_SPI_CS_B,
    input wire I_SPI_SCK,
    input wire I_SPI_SDI,
    input wire [1:0] I_PWM,
    input wire [1:0] I_CYCLE_START,
    input wire [1:0] I_OV_CMP,
    input wire [1:0] I_ILIM_CMP,
    input wire I_GATE_SUPPLY_GOOD,
    output reg O_SPI_SDO,
    output reg O_SPI_SDO_OE,
    output reg [1:0] O_GATE,
    output reg [1:0] O_SLOPE_COMP_EN,
    output reg O_GATE_SUPPLY_EN,
    output reg [7:0] O_OUT1_TARGET,
    output reg [7:0] O_OUT2_TARGET,
    output reg [7:0] O_OUT1_OV_LIMIT,
    output reg [7:0] O_OUT2_OV_LIMIT,
    output reg [7:0] O_OUT1_PEAK_LIMIT,
    output reg [7:0] O_OUT2_PEAK_LIMIT
);

    // Start-up wait as a sized terminal count.
    // The integer form is cut to the counter width on purpose; the default fits in sixteen bits.
    localparam integer STARTUP_LAST_INT = STARTUP_CYCLES - 1;
    localparam [STARTUP_WIDTH-1:0] STARTUP_LAST = STARTUP_LAST_INT[STARTUP_WIDTH-1:0];

    // Reset value of the implemented function control bits; the reserved upper nibble is dropped.
    localparam [7:0] FUNC_CTRL_RST = `BOCR_RST_FUNC_CTRL;
    localparam [3:0] FUNC_CTRL_RST_LOW = FUNC_CTRL_RST[3:0];

    // Function control bits that are implemented; bits 7 to 4 are not stored.
    reg [3:0] func_ctrl_reg;
    // Serial port edge detection and frame state.
    reg sck_q_reg;
    reg csb_q_reg;
    reg [4:0] bit_cnt_reg;
    reg [15:0] rx_shift_reg;
    reg [7:0] tx_shift_reg;
    // Chip select low counter and its per-frame arming flag.
    reg [COUNT_WIDTH-1:0] cs_low_count_value_reg;
    reg cs_count_armed_reg;
    // Gate supply start-up counter and ready flag.
    reg [STARTUP_WIDTH-1:0] startup_cnt_reg;
    reg gates_ready_reg;
    // Per-phase latch of a peak current hit within the switching cycle.
    reg [1:0] ilim_hit_reg;

    // Synchronised comparator levels.
    wire [1:0] ov_sync;
    wire [1:0] ilim_sync;

    // Decoded serial port events.
    wire sck_rise = I_SPI_SCK & ~sck_q_reg;
    wire sck_fall = ~I_SPI_SCK & sck_q_reg;
    wire csb_fall = ~I_SPI_CS_B & csb_q_reg;
    wire frame_act = ~I_SPI_CS_B;
    wire [15:0] rx_word = {rx_shift_reg[14:0], I_SPI_SDI};
    wire cmd_done = frame_act & sck_rise & (bit_cnt_reg == `BOCR_CMD_BITS - 5'h01);
    wire frame_done = frame_act & sck_rise & (bit_cnt_reg == `BOCR_FRAME_BITS - 5'h01);
    wire wr_strobe = frame_done & ~rx_word[`BOCR_FRAME_READ_BIT];
    wire [6:0] wr_addr = rx_word[14:8];
    wire [7:0] wr_data = rx_word[7:0];
    // The address of a read is the low seven bits of the first byte.
    wire [6:0] rd_addr = rx_word[6:0];

    // Mode and per-output on conditions.
    wire cfg_done = func_ctrl_reg[`BOCR_FC_CONFIGURATION_DONE];
    wire [1:0] out_on;
    reg [7:0] rd_data;
    reg [7:0] peak_wr_data;

    // Comparator levels cross into the oscillator domain first.
    bocr_sync #(
        .WIDTH(4)
    ) bocr_sync_i (
        .i_clk(I_REF_CLK),
        .i_rst_b(I_RST_B),
        .i_async({I_ILIM_CMP, I_OV_CMP}),
        .o_sync({ilim_sync, ov_sync})
    );

    // An output runs only in operation mode with its enable and non-zero codes.
    assign out_on[0] = cfg_done & func_ctrl_reg[`BOCR_FC_OUTPUT1_ENABLE]
        & (O_OUT1_TARGET != `BOCR_CODE_OFF)
        & (O_OUT1_OV_LIMIT != `BOCR_CODE_OFF);
    assign out_on[1] = cfg_done & func_ctrl_reg[`BOCR_FC_OUTPUT2_ENABLE]
        & (O_OUT2_TARGET != `BOCR_CODE_OFF)
        & (O_OUT2_OV_LIMIT != `BOCR_CODE_OFF);

    // Read data multiplexer; unmapped addresses and reserved bits read zero.
    always @* begin
        case (rd_addr)
            `BOCR_ADDR_FUNC_CTRL: rd_data = {4'h0, func_ctrl_reg};
            `BOCR_ADDR_OUT1_TARGET: rd_data = O_OUT1_TARGET;
            `BOCR_ADDR_OUT2_TARGET: rd_data = O_OUT2_TARGET;
            `BOCR_ADDR_OUT1_OV_LIMIT: rd_data = O_OUT1_OV_LIMIT;
            `BOCR_ADDR_OUT2_OV_LIMIT: rd_data = O_OUT2_OV_LIMIT;
            `BOCR_ADDR_OUT1_PEAK_LIMIT: rd_data = O_OUT1_PEAK_LIMIT;
            `BOCR_ADDR_OUT2_PEAK_LIMIT: rd_data = O_OUT2_PEAK_LIMIT;
            `BOCR_ADDR_CS_COUNT_LO: rd_data = cs_low_count_value_reg[7:0];
            `BOCR_ADDR_CS_COUNT_HI: rd_data = cs_low_count_value_reg[15:8];
            default: rd_data = 8'h00;
        endcase
    end

    // Peak current codes above the largest permitted code are clamped to it.
    always @* begin
        if (wr_data > `BOCR_PEAK_CODE_MAX) begin
            peak_wr_data = `BOCR_PEAK_CODE_MAX;
        end else begin
            // Codes up to the largest permitted one are kept as written.
            peak_wr_data = wr_data;
        end
    end

    // Serial port framing: bit counter, receive shift and transmit shift.
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            // Chip select rests high and the serial clock low, so no false edge follows reset.
            sck_q_reg <= 1'b0;
            csb_q_reg <= 1'b1;
            bit_cnt_reg <= 5'h00;
            rx_shift_reg <= 16'h0000;
            tx_shift_reg <= 8'h00;
            O_SPI_SDO <= 1'b0;
            O_SPI_SDO_OE <= 1'b0;
        end else begin
            sck_q_reg <= I_SPI_SCK;
            csb_q_reg <= I_SPI_CS_B;
            // Data out is driven only while the frame is selected.
            O_SPI_SDO_OE <= frame_act;
            if (!frame_act) begin
                // Deselect aborts any partial frame.
                bit_cnt_reg <= 5'h00;
                O_SPI_SDO <= 1'b0;
            end else if (sck_rise) begin
                // Sample data in on the rising clock edge.
                rx_shift_reg <= rx_word;
                if (frame_done) begin
                    // A complete frame lets a following frame start in the same select.
                    bit_cnt_reg <= 5'h00;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
                if (cmd_done) begin
                    // Read data is loaded once the address byte is complete.
                    // Write frames load it too; the master ignores those bits.
                    tx_shift_reg <= rd_data;
                end
            end else if (sck_fall) begin
                // Shift data out on the falling clock edge.
                O_SPI_SDO <= tx_shift_reg[7];
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    // Register writes; the lock blocks all but function control in operation mode.
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            // All codes reset to zero, which keeps both outputs off.
            func_ctrl_reg <= FUNC_CTRL_RST_LOW;
            O_OUT1_TARGET <= `BOCR_RST_CODE;
            O_OUT2_TARGET <= `BOCR_RST_CODE;
            O_OUT1_OV_LIMIT <= `BOCR_RST_CODE;
            O_OUT2_OV_LIMIT <= `BOCR_RST_CODE;
            O_OUT1_PEAK_LIMIT <= `BOCR_RST_CODE;
            O_OUT2_PEAK_LIMIT <= `BOCR_RST_CODE;
        end else if (wr_strobe) begin
            if (wr_addr == `BOCR_ADDR_FUNC_CTRL) begin
                // Reserved upper bits are dropped.
                func_ctrl_reg <= wr_data[3:0];
            end else if (!cfg_done) begin
                // Configuration mode: no lock.
                case (wr_addr)
                    `BOCR_ADDR_OUT1_TARGET: O_OUT1_TARGET <= wr_data;
                    `BOCR_ADDR_OUT2_TARGET: O_OUT2_TARGET <= wr_data;
                    `BOCR_ADDR_OUT1_OV_LIMIT: O_OUT1_OV_LIMIT <= wr_data;
                    `BOCR_ADDR_OUT2_OV_LIMIT: O_OUT2_OV_LIMIT <= wr_data;
                    `BOCR_ADDR_OUT1_PEAK_LIMIT: O_OUT1_PEAK_LIMIT <= peak_wr_data;
                    `BOCR_ADDR_OUT2_PEAK_LIMIT: O_OUT2_PEAK_LIMIT <= peak_wr_data;
                    // Count registers and unmapped addresses take no write.
                    default: ;
                endcase
            end
        end
    end

    // Chip select low time counter, armed at each select while the feature is enabled.
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            // The counter starts at zero and disarmed.
            cs_low_count_value_reg <= {COUNT_WIDTH{1'b0}};
            cs_count_armed_reg <= 1'b0;
        end else if (csb_fall) begin
            // A new frame restarts the count only when counting is enabled.
            cs_count_armed_reg <= func_ctrl_reg[`BOCR_FC_CS_LOW_COUNT_ENABLE];
            if (func_ctrl_reg[`BOCR_FC_CS_LOW_COUNT_ENABLE]) begin
                cs_low_count_value_reg <= {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end else if (frame_act & cs_count_armed_reg) begin
            // The frame that clears the enable is still measured whole, then frozen.
            if (cs_low_count_value_reg != {COUNT_WIDTH{1'b1}}) begin
                cs_low_count_value_reg <= cs_low_count_value_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end else if (!frame_act) begin
            // Deselect disarms the counter so a later frame with the enable clear leaves it frozen.
            cs_count_armed_reg <= 1'b0;
        end
    end

    // Gate supply regulator and start-up wait before any gate may switch.
    always @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_GATE_SUPPLY_EN <= 1'b0;
            startup_cnt_reg <= {STARTUP_WIDTH{1'b0}};
            gates_ready_reg <= 1'b0;
        end else begin
            // Regulator runs whenever either output is on.
            O_GATE_SUPPLY_EN <= |out_on;
            if (!O_GATE_SUPPLY_EN) begin
                // Regulator off: the wait starts over at the next turn-on.
                startup_cnt_reg <= {STARTUP_WIDTH{1'b0}};
                gates_ready_reg <= 1'b0;
            end else if (startup_cnt_reg != STARTUP_LAST) begin
                startup_cnt_reg <= startup_cnt_reg + {{(STARTUP_WIDTH-1){1'b0}}, 1'b1};
                gates_ready_reg <= 1'b0;
            end else begin
                // Start-up time has elapsed; switching also needs supply good.
                // A drop of supply good stops the gates at once without a new wait.
                gates_ready_reg <= I_GATE_SUPPLY_GOOD;
            end
        end
    end

    // Per-phase gate gating by overvoltage and cycle-by-cycle peak current limit.
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_phase
            // Peak code of this phase; zero keeps the phase idle.
            wire [7:0] peak_code = (p == 0) ? O_OUT1_PEAK_LIMIT : O_OUT2_PEAK_LIMIT;
            // The phase may run only after start-up with its output fully enabled.
            wire run = gates_ready_reg & out_on[p] & (peak_code != `BOCR_CODE_OFF);

            always @(posedge I_REF_CLK or negedge I_RST_B) begin
                if (!I_RST_B) begin
                    // Gates rest low so no switching follows reset.
                    ilim_hit_reg[p] <= 1'b0;
                    O_GATE[p] <= 1'b0;
                    O_SLOPE_COMP_EN[p] <= 1'b0;
                end else begin
                    // A hit holds the gate off until the next cycle; a hit wins over the restart.
                    if (ilim_sync[p]) begin
                        ilim_hit_reg[p] <= 1'b1;
                    end else if (I_CYCLE_START[p]) begin
                        ilim_hit_reg[p] <= 1'b0;
                    end
                    // Gate held low above the limit and toggles again below it.
                    O_GATE[p] <= run & I_PWM[p] & ~ov_sync[p] & ~ilim_sync[p] & ~ilim_hit_reg[p];
                    // Slope compensation is not dropped by the current limit.
                    O_SLOPE_COMP_EN[p] <= run;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- bench/bocr_top_chk.sv
// Purpose: Port checks of the boost output control block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound into every top module instance.
`timescale 1ns/1ns
`default_nettype none
module bocr_top_chk #(parameter STARTUP_CYCLES = 12500) (
    input wire I_REF_CLK, input wire I_RST_B, input wire I_SPI_CS_B, input wire I_SPI_SCK,
    input wire I_SPI_SDI, input wire [1:0] I_PWM, input wire [1:0] I_CYCLE_START,
    input wire [1:0] I_OV_CMP, input wire [1:0] I_ILIM_CMP, input wire I_GATE_SUPPLY_GOOD,
    input wire O_SPI_SDO, input wire O_SPI_SDO_OE, input wire [1:0] O_GATE,
    input wire [1:0] O_SLOPE_COMP_EN, input wire O_GATE_SUPPLY_EN, input wire [7:0] O_OUT1_TARGET,
    input wire [7:0] O_OUT2_TARGET, input wire [7:0] O_OUT1_OV_LIMIT, input wire [7:0] O_OUT2_OV_LIMIT,
    input wire [7:0] O_OUT1_PEAK_LIMIT, input wire [7:0] O_OUT2_PEAK_LIMIT
);
    logic [15:0] su_cnt; // Clocks since the gate supply came on.
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);
    // Saturating count of supply-on time, cleared while the supply is off.
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) su_cnt <= 16'h0000;
        else if (!O_GATE_SUPPLY_EN) su_cnt <= 16'h0000;
        else if (su_cnt != 16'hFFFF) su_cnt <= su_cnt + 16'h0001;
    end
    property p_tgt1; O_GATE[0] |-> $past(O_OUT1_TARGET) != 8'h00; endproperty
    a_tgt1: assert property (p_tgt1) else $error("gate ran on zero target");
    property p_lim1; O_GATE[0] |-> $past(O_OUT1_OV_LIMIT) != 8'h00; endproperty
    a_lim1: assert property (p_lim1) else $error("gate ran on zero limit");
    property p_peak; O_GATE[0] |-> $past(O_OUT1_PEAK_LIMIT) != 8'h00; endproperty
    a_peak: assert property (p_peak) else $error("gate ran on zero peak code");
    property p_ov; I_OV_CMP[0] [*3] |=> !O_GATE[0]; endproperty
    a_ov: assert property (p_ov) else $error("gate toggled above limit");
    property p_ilim; I_ILIM_CMP[1] [*3] ##1 !I_CYCLE_START[1] [*4] |=> !O_GATE[1]; endproperty
    a_ilim: assert property (p_ilim) else $error("gate back before next cycle");
    property p_slope; O_GATE[1] |-> O_SLOPE_COMP_EN[1]; endproperty
    a_slope: assert property (p_slope) else $error("slope compensation off");
    property p_sup; O_GATE != 2'h0 |-> O_GATE_SUPPLY_EN; endproperty
    a_sup: assert property (p_sup) else $error("gate without supply");
    property p_start; O_GATE != 2'h0 |-> {16'h0000, su_cnt} >= STARTUP_CYCLES - 1 && $past(I_GATE_SUPPLY_GOOD, 2);
    endproperty
    a_start: assert property (p_start) else $error("gate before supply start-up");
    property p_oe; O_SPI_SDO_OE == $past(!I_SPI_CS_B); endproperty
    a_oe: assert property (p_oe) else $error("data out enable does not follow chip select");
endmodule
bind bocr_top bocr_top_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) bocr_top_chk_i (.I_REF_CLK(I_REF_CLK),
    .I_RST_B(I_RST_B), .I_SPI_CS_B(I_SPI_CS_B), .I_SPI_SCK(I_SPI_SCK), .I_SPI_SDI(I_SPI_SDI), .I_PWM(I_PWM),
    .I_CYCLE_START(I_CYCLE_START), .I_OV_CMP(I_OV_CMP), .I_ILIM_CMP(I_ILIM_CMP), .O_GATE(O_GATE),
    .I_GATE_SUPPLY_GOOD(I_GATE_SUPPLY_GOOD), .O_SPI_SDO(O_SPI_SDO), .O_SPI_SDO_OE(O_SPI_SDO_OE),
    .O_SLOPE_COMP_EN(O_SLOPE_COMP_EN), .O_GATE_SUPPLY_EN(O_GATE_SUPPLY_EN), .O_OUT1_TARGET(O_OUT1_TARGET),
    .O_OUT2_TARGET(O_OUT2_TARGET), .O_OUT1_OV_LIMIT(O_OUT1_OV_LIMIT), .O_OUT2_OV_LIMIT(O_OUT2_OV_LIMIT),
    .O_OUT1_PEAK_LIMIT(O_OUT1_PEAK_LIMIT), .O_OUT2_PEAK_LIMIT(O_OUT2_PEAK_LIMIT));
`default_nettype wire

//--- bench/bocr_spi_master.sv
// Purpose: Microcontroller model that sends serial frames to the block.
// Assumes: Mode 0, most significant bit first, sixteen bits a frame.
// Notes: Measures each chip-select low time in reference clocks.
`timescale 1ns/1ns
`default_nettype none
module bocr_spi_master (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_sdi
);
    logic [15:0] cur_len = 16'h0000; // Clocks of the running frame.
    logic [15:0] last_len = 16'h0000; // Clocks of the last finished frame.
    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
    // Counts the edges at which chip select is seen low.
    always @(posedge i_clk) begin
        if (!o_cs_b) begin
            cur_len <= cur_len + 16'h0001;
        end else if (cur_len != 16'h0000) begin
            last_len <= cur_len;
            cur_len <= 16'h0000;
        end
    end
    // Sends one frame, or only its first nb bits to model a cut frame.
    // The clock rests low outside frames and each level lasts several clocks.
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd, input int nb = 16);
        @(posedge i_clk);
        o_cs_b <= 1'b0;
        for (int i = 15; i >= 16 - nb; i--) begin
            o_sck <= 1'b0;
            o_sdi <= f[i];
            repeat (3) @(posedge i_clk);
            rd = {rd[6:0], i_sdo};
            o_sck <= 1'b1;
            repeat (2) @(posedge i_clk);
        end
        o_sck <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_cs_b <= 1'b1;
        o_sdi <= ~o_sdi; // A released data line shows no stale bit.
        repeat (3) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- bench/bocr_top_tb.sv
// Purpose: Self-checking bench for the boost output control block.
// Assumes: The serial master model issues every register access.
// Notes: Start-up time shortened to 20 clocks.
`timescale 1ns/1ns
`default_nettype none
module bocr_top_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic good = 1'b1;
    logic [1:0] pwm = 2'h0, cyc = 2'h0, ov = 2'h0, ilim = 2'h0;
    wire cs_b, sck, sdi, sdo, sup_en;
    wire [1:0] gate, slope;
    wire [7:0] t1, t2, l1, l2, p1, p2;
    wire [47:0] outs = {p2, p1, l2, l1, t2, t1}; // Register outputs by offset.
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] val [3:8] = '{8'h80, 8'h60, 8'h8E, 8'h6E, 8'h40, 8'h40}; // Limits 14 codes above targets.
    logic [6:0] al [10] = '{7'h00, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h41, 7'h42, 7'h20};
    logic [6:0] zc [6] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08};
    bocr_top #(.STARTUP_CYCLES(20)) bocr_top_i (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_SPI_CS_B(cs_b),
        .I_SPI_SCK(sck), .I_SPI_SDI(sdi), .I_PWM(pwm), .I_CYCLE_START(cyc), .I_OV_CMP(ov), .I_ILIM_CMP(ilim),
        .I_GATE_SUPPLY_GOOD(good), .O_SPI_SDO(sdo), .O_SPI_SDO_OE(), .O_GATE(gate), .O_SLOPE_COMP_EN(slope),
        .O_GATE_SUPPLY_EN(sup_en), .O_OUT1_TARGET(t1), .O_OUT2_TARGET(t2), .O_OUT1_OV_LIMIT(l1),
        .O_OUT2_OV_LIMIT(l2), .O_OUT1_PEAK_LIMIT(p1), .O_OUT2_PEAK_LIMIT(p2));
    bocr_spi_master bocr_spi_master_i (.i_clk(clk), .i_sdo(sdo), .o_cs_b(cs_b), .o_sck(sck), .o_sdi(sdi));
    always #4 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        bocr_spi_master_i.xfer({1'b0, a, d}, v);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        bocr_spi_master_i.xfer({1'b1, a, 8'h00}, v);
        check(v, e);
    endtask
    // Waits a bounded number of clocks for the gate pair to reach e.
    task automatic wg(input logic [1:0] e, input int n);
        for (int k = 0; k < n && gate !== e; k++) @(posedge clk);
        check({6'h00, gate}, {6'h00, e});
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        logic [15:0] cnt;
        logic [7:0] v;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (al[j]) rdc(al[j], 8'h00);
        $display("test reset done");
        for (int a = 3; a <= 8; a++) wr(7'(a), val[a]);
        for (int a = 3; a <= 8; a++) begin
            rdc(7'(a), val[a]);
            check(outs[(a-3)*8 +: 8], val[a]);
        end
        wr(7'h08, 8'hFF);
        rdc(7'h08, 8'h80);
        wr(7'h08, 8'h40);
        bocr_spi_master_i.xfer({1'b0, 7'h04, 8'h11}, v, 15);
        rdc(7'h04, 8'h60);
        $display("test registers done");
        pwm <= 2'h3;
        wr(7'h00, 8'h07);
        wg(2'h3, 60);
        check({7'h00, sup_en}, 8'h01);
        wr(7'h03, 8'h22);
        rdc(7'h03, 8'h80);
        wr(7'h08, 8'h10);
        rdc(7'h08, 8'h40);
        ov <= 2'h1;
        wg(2'h2, 6);
        ov <= 2'h0;
        wg(2'h3, 6);
        ilim <= 2'h2;
        repeat (4) @(posedge clk);
        ilim <= 2'h0;
        repeat (6) @(posedge clk);
        check({6'h00, gate}, 8'h01);
        check({6'h00, slope}, 8'h03);
        cyc <= 2'h2;
        @(posedge clk);
        cyc <= 2'h0;
        wg(2'h3, 6);
        good <= 1'b0;
        wg(2'h0, 6);
        good <= 1'b1;
        wg(2'h3, 60);
        wr(7'h00, 8'h05);
        wg(2'h2, 60);
        wr(7'h00, 8'h03);
        wg(2'h1, 60);
        wr(7'h00, 8'h06);
        wg(2'h0, 6);
        repeat (2) @(posedge clk);
        check({7'h00, sup_en}, 8'h00);
        $display("test drive done");
        foreach (zc[j]) begin
            wr(zc[j], 8'h00);
            wr(7'h00, 8'h07);
            wg(zc[j][0] ? 2'h2 : 2'h1, 60);
            wr(7'h00, 8'h00);
            wr(zc[j], val[zc[j]]);
        end
        $display("test zero codes done");
        wr(7'h00, 8'h08);
        wr(7'h03, 8'h80);
        wr(7'h00, 8'h00);
        cnt = bocr_spi_master_i.last_len;
        rdc(7'h41, cnt[7:0]);
        rdc(7'h42, cnt[15:8]);
        wr(7'h41, 8'hFF);
        rdc(7'h41, cnt[7:0]);
        $display("test count done");
        report_and_stop();
    end
endmodule
`default_nettype wire
